// ===== include/sarc_params.svh
// Constants of the synchronous DRAM read/write/activate model: mode fields, resets, offsets.
// Assumes inclusion by bare name from the package and the device module.
`ifndef SARC_PARAMS_SVH
`define SARC_PARAMS_SVH
`define SARC_ADDR_W 12
`define SARC_AV_AW 5
`define SARC_BL_HI 2
`define SARC_BL_PAGE 3'h7
`define SARC_BT_BIT 3
`define SARC_CL_LO 4
`define SARC_CL_HI 6
`define SARC_CL_TWO 3'h2
`define SARC_OP_LO 7
`define SARC_OP_HI 8
`define SARC_OP_NORMAL 2'h0
`define SARC_WB_BIT 9
`define SARC_AP_BIT 10
`define SARC_MODE_RST 12'h022
`define SARC_REG_MODE 5'h00
`define SARC_REG_STATUS 5'h04
`define SARC_REG_MEM_ADDR 5'h08
`define SARC_REG_MEM_DATA 5'h0c
`define SARC_ST_RD_BIT 4
`define SARC_ST_WR_BIT 5
`define SARC_ST_MODE_ERR 8
`define SARC_ST_CMD_ERR 9
`endif

// ===== include/sarc_pkg.sv
// Types shared by the DRAM device model and its bench: command codes and pin groups.
// Assumes sarc_params.svh is on the include path.
package sarc_pkg;
`include "sarc_params.svh"
    typedef enum logic [2:0] {
        SARC_CMD_LOAD_MODE = 3'h0,
        SARC_CMD_REFRESH = 3'h1,
        SARC_CMD_PRECHARGE = 3'h2,
        SARC_CMD_ACTIVE = 3'h3,
        SARC_CMD_WRITE = 3'h4,
        SARC_CMD_READ = 3'h5,
        SARC_CMD_TERMINATE = 3'h6,
        SARC_CMD_NOP = 3'h7
    } sarc_cmd_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] ba;
        logic [`SARC_ADDR_W-1:0] addr;
        logic dqm;
    } sarc_pins_t;

    typedef struct packed {
        logic [`SARC_AV_AW-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } sarc_av_req_t;
endpackage

// ===== verilog/sarc_device.sv
// Device side of a synchronous DRAM: mode register, bank activation, read and write bursts.
// Assumes all pins are synchronous to clock_i and the controller keeps its own timing.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`include "sarc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sarc_device #(
    parameter int DQ_W = 32,
    parameter int COL_W = 8
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire sarc_pkg::sarc_pins_t pin_i,
    input wire logic [DQ_W-1:0] dq_i,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe_n_o,
    input wire sarc_pkg::sarc_av_req_t av_i,
    output logic [31:0] av_readdata_o,
    output logic av_waitrequest_o
);
    localparam int MEM_AW = COL_W + 2;

    logic [`SARC_ADDR_W-1:0] mode;
    logic [3:0] bank_open;
    logic [3:0] next_bank_open;
    logic [DQ_W-1:0] mem [1 << MEM_AW];
    logic rd_active, rd_ap;
    logic [1:0] rd_bank;
    logic [COL_W-1:0] rd_start, rd_k;
    logic wr_active, wr_ap;
    logic [1:0] wr_bank;
    logic [COL_W-1:0] wr_start, wr_k;
    logic stage_valid, dqm_d;
    logic [DQ_W-1:0] stage_data;
    logic mode_err, cmd_err;
    logic [MEM_AW-1:0] mem_addr, pend_addr;
    logic pend;
    logic [DQ_W-1:0] pend_data;

    function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] start,
            input logic [COL_W-1:0] k, input logic [COL_W-1:0] mask, input logic il);
        logic [COL_W-1:0] low;
        low = il ? (start ^ k) : (start + k);
        return (start & ~mask) | (low & mask);
    endfunction

    // Command decode; a deselected device sees a NOP.
    sarc_pkg::sarc_cmd_t cmd;
    assign cmd = pin_i.cs_n ? sarc_pkg::SARC_CMD_NOP
                            : sarc_pkg::sarc_cmd_t'({pin_i.ras_n, pin_i.cas_n, pin_i.we_n});
    wire [COL_W-1:0] cmd_col = pin_i.addr[COL_W-1:0];
    wire cmd_ap = pin_i.addr[`SARC_AP_BIT];
    wire bank_hit = bank_open[pin_i.ba];
    wire is_act = cmd == sarc_pkg::SARC_CMD_ACTIVE;
    wire is_rd = cmd == sarc_pkg::SARC_CMD_READ;
    wire is_wr = cmd == sarc_pkg::SARC_CMD_WRITE;
    wire is_bst = cmd == sarc_pkg::SARC_CMD_TERMINATE;
    wire is_pre = cmd == sarc_pkg::SARC_CMD_PRECHARGE;
    wire is_lmr = cmd == sarc_pkg::SARC_CMD_LOAD_MODE;

    // Mode fields.
    wire [2:0] bl_code = mode[`SARC_BL_HI:0];
    wire bl_page = bl_code == `SARC_BL_PAGE;
    wire [COL_W-1:0] rd_mask = bl_page ? '1 : ((COL_W'(1) << bl_code[1:0]) - COL_W'(1));
    wire single_wr = mode[`SARC_WB_BIT];
    wire [COL_W-1:0] wr_mask = single_wr ? '0 : rd_mask;
    wire wr_page = bl_page && !single_wr;
    wire il = mode[`SARC_BT_BIT] && !bl_page;
    wire cl_two = mode[`SARC_CL_HI:`SARC_CL_LO] == `SARC_CL_TWO;
    wire op_bad = pin_i.addr[`SARC_OP_HI:`SARC_OP_LO] != `SARC_OP_NORMAL;
    wire mode_load = is_lmr && !op_bad && bank_open == 4'h0;

    // Read side.
    wire rd_acc = is_rd && bank_hit;
    wire read_busy = rd_active || stage_valid || !dq_oe_n_o;
    // A WRITE that cuts a read is only honoured if the mask was up the clock before.
    wire wr_acc = is_wr && bank_hit && (!read_busy || dqm_d);
    wire rd_stop = is_bst || wr_acc || (is_pre && (cmd_ap || pin_i.ba == rd_bank));
    wire rd_last = !bl_page && rd_k == rd_mask;
    wire [COL_W-1:0] rd_col = col_of(rd_start, rd_k, rd_mask, il);
    wire [DQ_W-1:0] elem_data = mem[{rd_bank, rd_col}];
    wire sel_valid = cl_two ? rd_active : stage_valid;
    wire [DQ_W-1:0] sel_data = cl_two ? elem_data : stage_data;
    // Output mask latency is two clocks: dqm_d gates the update that drives the next edge.
    wire next_oe_n = !(sel_valid && !dqm_d) || wr_acc;
    wire rd_ap_fin = rd_active && rd_ap && (rd_last || rd_stop || rd_acc);

    // Write side.
    wire wr_stop = is_rd || is_wr || is_bst || (is_pre && (cmd_ap || pin_i.ba == wr_bank));
    wire wr_last = !wr_page && wr_k == wr_mask;
    wire wr_step = wr_active && !wr_stop;
    wire wr_ap_now = wr_acc && cmd_ap && wr_mask == '0;
    wire wr_ap_fin = wr_ap_now || (wr_active && wr_ap && (wr_last || wr_stop));
    wire [1:0] wr_ap_bank = wr_ap_now ? pin_i.ba : wr_bank;
    wire sd_we = (wr_acc || wr_step) && !pin_i.dqm;
    wire [MEM_AW-1:0] sd_wa = wr_acc ? {pin_i.ba, cmd_col}
                                     : {wr_bank, col_of(wr_start, wr_k, wr_mask, il)};
    wire bad_cmd = ((is_rd || is_wr) && !bank_hit) || (is_wr && bank_hit && !wr_acc)
                   || (is_act && bank_hit) || (is_lmr && bank_open != 4'h0);

    // Register bus decode.
    wire av_req = av_i.read || av_i.write;
    wire av_take = av_req && !av_waitrequest_o;
    wire av_wr = av_take && av_i.write;
    wire sel_mode = av_i.address == `SARC_REG_MODE;
    wire sel_status = av_i.address == `SARC_REG_STATUS;
    wire sel_maddr = av_i.address == `SARC_REG_MEM_ADDR;
    wire sel_mdata = av_i.address == `SARC_REG_MEM_DATA;
    wire clr_mode_err = av_wr && sel_status && av_i.writedata[`SARC_ST_MODE_ERR];
    wire clr_cmd_err = av_wr && sel_status && av_i.writedata[`SARC_ST_CMD_ERR];
    wire [31:0] status_word = {22'h0, cmd_err, mode_err, 2'h0, wr_active, rd_active, bank_open};
    wire [31:0] rdata_sel = sel_mode ? 32'(mode)
                          : sel_status ? status_word
                          : sel_maddr ? 32'(mem_addr)
                          : sel_mdata ? 32'(mem[mem_addr]) : 32'h0;

    always_comb begin
        next_bank_open = bank_open;
        if (rd_ap_fin) begin
            next_bank_open[rd_bank] = 1'b0;
        end
        if (wr_ap_fin) begin
            next_bank_open[wr_ap_bank] = 1'b0;
        end
        if (is_pre) begin
            if (cmd_ap) begin
                next_bank_open = 4'h0;
            end else begin
                next_bank_open[pin_i.ba] = 1'b0;
            end
        end
        if (is_act) begin
            next_bank_open[pin_i.ba] = 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode <= `SARC_MODE_RST;
            bank_open <= 4'h0;
            mode_err <= 1'b0;
            cmd_err <= 1'b0;
        end else begin
            bank_open <= next_bank_open;
            if (mode_load) begin
                mode <= pin_i.addr;
            end
            mode_err <= (is_lmr && op_bad) || (mode_err && !clr_mode_err);
            cmd_err <= bad_cmd || (cmd_err && !clr_cmd_err);
        end
    end

    // A new READ simply reloads the engine; elements already in flight keep the bus busy.
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_active <= 1'b0;
            rd_ap <= 1'b0;
            rd_bank <= 2'h0;
            rd_start <= '0;
            rd_k <= '0;
        end else if (rd_acc) begin
            rd_active <= 1'b1;
            rd_ap <= cmd_ap && !bl_page;
            rd_bank <= pin_i.ba;
            rd_start <= cmd_col;
            rd_k <= '0;
        end else if (rd_stop || rd_last) begin
            rd_active <= 1'b0;
        end else begin
            rd_k <= rd_k + COL_W'(1);
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stage_valid <= 1'b0;
            stage_data <= '0;
            dqm_d <= 1'b0;
            dq_o <= '0;
            dq_oe_n_o <= 1'b1;
        end else begin
            stage_valid <= rd_active && !wr_acc;
            stage_data <= elem_data;
            dqm_d <= pin_i.dqm;
            dq_o <= sel_data;
            dq_oe_n_o <= next_oe_n;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_active <= 1'b0;
            wr_ap <= 1'b0;
            wr_bank <= 2'h0;
            wr_start <= '0;
            wr_k <= '0;
        end else if (wr_acc) begin
            wr_active <= wr_mask != '0 || wr_page;
            wr_ap <= cmd_ap && !wr_page;
            wr_bank <= pin_i.ba;
            wr_start <= cmd_col;
            wr_k <= COL_W'(1);
        end else if (wr_stop || wr_last) begin
            wr_active <= 1'b0;
        end else begin
            wr_k <= wr_k + COL_W'(1);
        end
    end

    // Bus writes to the array wait in a pending slot so a DRAM write never loses its slot.
    always_ff @(posedge clock_i) begin
        if (sd_we) begin
            mem[sd_wa] <= dq_i;
        end else if (pend) begin
            mem[pend_addr] <= pend_data;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            av_waitrequest_o <= 1'b1;
            av_readdata_o <= 32'h0;
            mem_addr <= '0;
            pend <= 1'b0;
            pend_addr <= '0;
            pend_data <= '0;
        end else begin
            av_waitrequest_o <= !(av_req && av_waitrequest_o && !pend);
            av_readdata_o <= rdata_sel;
            if (av_wr && sel_maddr) begin
                mem_addr <= av_i.writedata[MEM_AW-1:0];
            end
            if (av_wr && sel_mdata) begin
                pend <= 1'b1;
                pend_addr <= mem_addr;
                pend_data <= DQ_W'(av_i.writedata);
            end else if (!sd_we) begin
                pend <= 1'b0;
            end
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    lat_two_a: assert property (rd_acc && cl_two && !pin_i.dqm ##1 !wr_acc |=> !dq_oe_n_o)
        else $error("read data not driven at latency two");
    lat_three_a: assert property (rd_acc && !cl_two ##1 !wr_acc && !pin_i.dqm ##1 !wr_acc
        |=> !dq_oe_n_o)
        else $error("read data not driven at latency three");
    early_drive_a: assert property (rd_acc && !cl_two && !read_busy |-> ##2 dq_oe_n_o)
        else $error("data lines driven before latency minus one");
    line_release_a: assert property (!rd_active && !stage_valid |=> dq_oe_n_o)
        else $error("data lines still driven after burst");
    write_float_a: assert property (wr_acc |=> dq_oe_n_o)
        else $error("data lines driven after truncating write");
    bad_write_a: assert property (is_wr && read_busy && !dqm_d |=> cmd_err && !wr_active)
        else $error("unmasked truncating write not refused");
    term_stop_a: assert property (is_bst |=> !rd_active)
        else $error("burst terminate did not stop read");
    page_run_a: assert property (rd_active && bl_page && !rd_stop |=> rd_active)
        else $error("page burst ended on its own");
    burst_step_a: assert property (rd_active && !rd_last && !rd_stop && !rd_acc
        |=> rd_active && rd_k == COL_W'($past(rd_k) + 1'b1))
        else $error("burst did not advance one element");
    ap_close_a: assert property (rd_active && rd_ap && rd_last && !rd_stop && !is_act
        |=> !bank_open[$past(rd_bank)])
        else $error("auto precharge left bank open");
    single_write_a: assert property (wr_acc && single_wr |=> !wr_active)
        else $error("write burst in single write mode");
    mode_keep_a: assert property (is_lmr && op_bad |=> mode == $past(mode))
        else $error("reserved operating mode loaded");
    read_take_a: assert property (rd_acc |=> rd_active && rd_k == '0)
        else $error("read command not taken");

    seamless_c: cover property (rd_active && rd_acc ##1 rd_active);
    term_c: cover property (rd_active && is_bst);
    trunc_write_c: cover property (rd_active && dqm_d && wr_acc);
    bus_read_c: cover property (av_take && av_i.read && sel_status);
endmodule

`default_nettype wire

// ===== tb/sarc_ctrl.sv
// Controller model that issues commands on the pin group of the device.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module sarc_ctrl #(
    parameter int ACT_CYC = 3,
    parameter int PRE_CYC = 3
) (
    input wire logic clock_i,
    output var sarc_pkg::sarc_pins_t pin_o
);
    int cyc = 0;
    int last_edge = 0;
    logic [3:0] open_bank = 4'h0;
    initial pin_o = '1;
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
    end
    task automatic cmd(input logic [2:0] op, input logic [1:0] ba, input logic [11:0] a,
                       input logic dqm);
        pin_o <= {1'b0, op, ba, a, dqm};
        @(posedge clock_i);
        last_edge = cyc;
    endtask
    // The caller never asks for zero cycles, so no signal is driven twice in a step.
    task automatic idle(input int n, input logic dqm);
        pin_o <= {1'b1, 3'h7, 2'h0, 12'h000, dqm};
        repeat (n) @(posedge clock_i);
    endtask
    task automatic pre(input logic [1:0] ba);
        cmd(sarc_pkg::SARC_CMD_PRECHARGE, ba, 12'h000, 1'b0);
        open_bank[ba] = 1'b0;
        idle(PRE_CYC - 1, 1'b0);
    endtask
    task automatic act(input logic [1:0] ba);
        if (open_bank[ba]) begin
            pre(ba);
        end
        cmd(sarc_pkg::SARC_CMD_ACTIVE, ba, 12'h001, 1'b0);
        open_bank[ba] = 1'b1;
        idle(ACT_CYC - 1, 1'b0);
    endtask
    task automatic rd(input logic [1:0] ba, input logic [7:0] col, input logic ap);
        cmd(sarc_pkg::SARC_CMD_READ, ba, {1'b0, ap, 2'h0, col}, 1'b0);
        if (ap) begin
            open_bank[ba] = 1'b0;
        end
    endtask
    // Loading is only asked for with every bank closed.
    task automatic load(input logic [11:0] word);
        cmd(sarc_pkg::SARC_CMD_LOAD_MODE, 2'h0, word, 1'b0);
        idle(2, 1'b0);
    endtask
endmodule
`default_nettype wire

// ===== tb/sarc_device_tb.sv
// Self-checking bench of the DRAM device: bursts on the pins, registers over Avalon-MM.
// Assumes the controller model sarc_ctrl drives the command pins.
`timescale 1ns/1ps
`default_nettype none
module sarc_device_tb;
    logic clock_i = 1'b0;
    logic sys_rst_i;
    sarc_pkg::sarc_pins_t pin;
    logic [31:0] dq_i;
    logic [31:0] dq_o;
    logic dq_oe_n_o;
    sarc_pkg::sarc_av_req_t av_i;
    logic [31:0] av_readdata_o;
    logic av_waitrequest_o;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    int t0;
    logic [31:0] rv;
    logic [31:0] dq_q[$];
    int st_q[$];
    sarc_ctrl u_sarc_ctrl (.clock_i(clock_i), .pin_o(pin));
    sarc_device u_sarc_device (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .pin_i(pin),
        .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .av_i(av_i),
        .av_readdata_o(av_readdata_o), .av_waitrequest_o(av_waitrequest_o));
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        if (dq_oe_n_o === 1'b0) begin
            dq_q.push_back(dq_o);
            st_q.push_back(u_sarc_ctrl.cyc);
        end
    end
    task automatic end_sim();
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // The whole run needs well under two thousand cycles.
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] pat(input int c);
        return 32'hc0de_0000 + 32'(c);
    endfunction
    task automatic av(input logic [4:0] a, input logic wr, input logic [31:0] wd);
        av_i <= '{a, ~wr, wr, wd};
        do begin
            @(posedge clock_i);
        end while (av_waitrequest_o !== 1'b0);
        rv = av_readdata_o;
        av_i <= '0;
        @(posedge clock_i);
    endtask
    task automatic clr();
        dq_q.delete();
        st_q.delete();
    endtask
    task automatic chk_burst(input int cols[$], input int lat);
        check("burst length", 32'(dq_q.size()), 32'(cols.size()));
        foreach (cols[k]) begin
            check("burst data", dq_q[k], pat(cols[k]));
            check("burst timing", 32'(st_q[k]), 32'(t0 + lat + k));
        end
    endtask
    task automatic s_reset();
        check("idle lines", {31'h0, dq_oe_n_o}, 32'h1);
        av(5'h00, 1'b0, 32'h0);
        check("mode at reset", rv, 32'h022);
        av(5'h14, 1'b0, 32'h0);
        check("unmapped read", rv, 32'h0);
        for (int k = 0; k < 10; k++) begin
            av(5'h08, 1'b1, 32'h100 + 32'(k < 8 ? k : k + 246));
            av(5'h0c, 1'b1, pat(k < 8 ? k : k + 246));
        end
    endtask
    task automatic s_burst();
        u_sarc_ctrl.act(2'h1);
        av(5'h04, 1'b0, 32'h0);
        check("bank open", rv, 32'h2);
        clr();
        u_sarc_ctrl.rd(2'h1, 8'h01, 1'b1);
        t0 = u_sarc_ctrl.last_edge;
        u_sarc_ctrl.idle(8, 1'b0);
        chk_burst('{1, 2, 3, 0}, 2);
        av(5'h04, 1'b0, 32'h0);
        check("auto precharge", rv, 32'h0);
    endtask
    task automatic s_pair();
        u_sarc_ctrl.act(2'h1);
        clr();
        u_sarc_ctrl.rd(2'h1, 8'h04, 1'b0);
        t0 = u_sarc_ctrl.last_edge;
        u_sarc_ctrl.rd(2'h1, 8'h00, 1'b0);
        u_sarc_ctrl.idle(6, 1'b0);
        chk_burst('{4, 0, 1, 2, 3}, 2);
        clr();
        u_sarc_ctrl.rd(2'h1, 8'h00, 1'b0);
        t0 = u_sarc_ctrl.last_edge;
        u_sarc_ctrl.idle(1, 1'b0);
        u_sarc_ctrl.pre(2'h1);
        u_sarc_ctrl.idle(4, 1'b0);
        chk_burst('{0, 1}, 2);
    endtask
    task automatic s_page();
        u_sarc_ctrl.load(12'h037);
        av(5'h00, 1'b0, 32'h0);
        check("page mode", rv, 32'h037);
        u_sarc_ctrl.act(2'h1);
        clr();
        u_sarc_ctrl.rd(2'h1, 8'hfe, 1'b0);
        t0 = u_sarc_ctrl.last_edge;
        u_sarc_ctrl.idle(3, 1'b0);
        u_sarc_ctrl.cmd(sarc_pkg::SARC_CMD_TERMINATE, 2'h1, 12'h000, 1'b0);
        u_sarc_ctrl.idle(6, 1'b0);
        chk_burst('{254, 255, 0, 1}, 3);
        u_sarc_ctrl.pre(2'h1);
        u_sarc_ctrl.load(12'h0a2);
        av(5'h00, 1'b0, 32'h0);
        check("reserved mode kept out", rv, 32'h037);
        av(5'h04, 1'b0, 32'h0);
        check("mode error", rv, 32'h100);
        av(5'h04, 1'b1, 32'h100);
        av(5'h04, 1'b0, 32'h0);
        check("mode error cleared", rv, 32'h0);
    endtask
    // Read cut short by a single-column write, mask raised two clocks ahead.
    task automatic s_write();
        u_sarc_ctrl.load(12'h222);
        u_sarc_ctrl.act(2'h1);
        clr();
        u_sarc_ctrl.rd(2'h1, 8'h00, 1'b0);
        t0 = u_sarc_ctrl.last_edge;
        u_sarc_ctrl.idle(2, 1'b1);
        dq_i <= 32'h1234_5678;
        u_sarc_ctrl.cmd(sarc_pkg::SARC_CMD_WRITE, 2'h1, 12'h002, 1'b0);
        dq_i <= 32'hedcb_a987;
        u_sarc_ctrl.idle(4, 1'b0);
        check("data before mask", dq_q[0], pat(0));
        check("lines float", {31'h0, st_q[$] <= u_sarc_ctrl.last_edge}, 32'h1);
        av(5'h04, 1'b0, 32'h0);
        check("write accepted", rv, 32'h2);
        av(5'h08, 1'b1, 32'h102);
        av(5'h0c, 1'b0, 32'h0);
        check("written word", rv, 32'h1234_5678);
        av(5'h08, 1'b1, 32'h103);
        av(5'h0c, 1'b0, 32'h0);
        check("single column", rv, pat(3));
        // A write right after a read, with the mask low, must be refused and flagged.
        clr();
        u_sarc_ctrl.rd(2'h1, 8'h00, 1'b0);
        dq_i <= 32'h0bad_0bad;
        u_sarc_ctrl.cmd(sarc_pkg::SARC_CMD_WRITE, 2'h1, 12'h003, 1'b0);
        u_sarc_ctrl.idle(6, 1'b0);
        check("unmasked write burst", 32'(dq_q.size()), 32'h4);
        av(5'h04, 1'b0, 32'h0);
        check("unmasked write refused", rv, 32'h202);
        av(5'h04, 1'b1, 32'h200);
        av(5'h04, 1'b0, 32'h0);
        check("command error cleared", rv, 32'h2);
        av(5'h0c, 1'b0, 32'h0);
        check("refused write not stored", rv, pat(3));
    endtask
    initial begin
        sys_rst_i = 1'b1;
        av_i = '0;
        dq_i = '0;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        s_reset();
        s_burst();
        s_pair();
        s_page();
        s_write();
        end_sim();
    end
endmodule
`default_nettype wire
